// *** core/ldc_map.vh ***
// register map, descriptor field positions and type codes of the checker
`ifndef LDC_MAP_VH
`define LDC_MAP_VH

// register byte addresses
`define LDC_A_DW0 7'h00
`define LDC_A_DW1 7'h04
`define LDC_A_DW2 7'h08
`define LDC_A_DW3 7'h0c
`define LDC_A_CTRL 7'h10
`define LDC_A_SEL 7'h14
`define LDC_A_START 7'h18
`define LDC_A_STAT 7'h1c
`define LDC_A_OFF_LO 7'h20
`define LDC_A_OFF_HI 7'h24
`define LDC_A_LIMIT 7'h28
`define LDC_A_TSEL 7'h2c
`define LDC_A_TSSB_LO 7'h30
`define LDC_A_TSSB_HI 7'h34
`define LDC_A_IVTA 7'h38
`define LDC_A_STK_LO 7'h3c
`define LDC_A_STK_HI 7'h40

// control register fields
`define LDC_C_LONG 0
`define LDC_C_M64 1
`define LDC_C_OP_LO 2
`define LDC_C_OP_HI 3
`define LDC_C_CSL 4
`define LDC_C_CSD 5
`define LDC_C_VEC_LO 8
`define LDC_C_VEC_HI 15

// check kinds
`define LDC_OP_SYS 2'h0
`define LDC_OP_GATE 2'h1
`define LDC_OP_INT 2'h2
`define LDC_OP_LEG 2'h3

// status register fields
`define LDC_S_DONE 0
`define LDC_S_FAULT 1
`define LDC_S_TYPE_LO 4
`define LDC_S_TYPE_HI 7
`define LDC_S_ISTUSE 8
`define LDC_S_IST_LO 9
`define LDC_S_IST_HI 11
`define LDC_S_CODE_LO 16
`define LDC_S_CODE_HI 31

// descriptor fields inside the second doubleword (and the fourth)
`define LDC_D_TYPE_LO 8
`define LDC_D_TYPE_HI 11
`define LDC_D_SBIT 12
`define LDC_D_GRAN 23
`define LDC_D_IST_HI 2

// type codes
`define LDC_T_T16A 4'h1
`define LDC_T_LDT 4'h2
`define LDC_T_T16B 4'h3
`define LDC_T_G16LO 4'h4
`define LDC_T_G16HI 4'h7
`define LDC_T_TSSA 4'h9
`define LDC_T_TSSB 4'hb
`define LDC_T_CALL 4'hc
`define LDC_T_INTG 4'he
`define LDC_T_TRAP 4'hf

`define LDC_GRAN_FILL 12'hfff
`define LDC_IVT_SH 4
`define LDC_STK_SH 3
`define LDC_RESP_OK 2'h0
`define LDC_RESP_ERR 2'h2

`endif

// *** core/ldc_canon.v ***
// canonical-form test of a 64-bit linear address
module ldc_canon #(
	parameter VA_BITS = 48
) (
	input wire [63:0] addr,
	output wire ok
);
	wire [64-VA_BITS:0] top;

	// the sign-extension bits must all repeat the highest implemented bit
	assign top = addr[63:VA_BITS-1];
	assign ok = (&top) | ~(|top);
endmodule // ldc_canon

// *** core/ldc_checker.v ***
// long-mode descriptor checker with an AXI4-Lite register slave
// Function
// - long mode: 02h,09h,0Bh are 64-bit table/task types
// - long mode: system types 01h,03h fault
// - 64-bit mode system descriptors are 16 bytes
// - expanded form only in 64-bit; compat legacy
// - noncanonical system base faults with selector
// - limit checked in both modes, granularity scaled
// - system upper-half type bits zero, legacy access faults
// - long mode: 0Ch,0Eh,0Fh are 64-bit gates
// - long mode: gate types 04h..07h fault
// - gates always 16 bytes in long mode
// - gate offset from three fields, selector dword0
// - stack index bits 2:0 of interrupt/trap gates
// - nonzero index selects stack entry, zero legacy
// - target code must be long, not default-size
// - noncanonical gate offset faults with zero code
// - call gate upper type bits zero, legacy faults
// - interrupt/trap upper type bits not checked
// - vector table entry at vector times sixteen
//
// Chosen here: the AXI4-Lite register port and the address map.
`include "ldc_map.vh"

module ldc_checker #(
	parameter VA_BITS = 48,
	parameter [31:0] TSS_MIN_LIM = 32'h00000067,
	parameter [63:0] STK_TBL_OFF = 64'h0000000000000024
) (
	input wire CLK_SYS,
	input wire RST_B,
	input wire [6:0] S_AXI_AWADDR,
	input wire [2:0] S_AXI_AWPROT,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [6:0] S_AXI_ARADDR,
	input wire [2:0] S_AXI_ARPROT,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	output reg FAULT,
	output reg [15:0] FAULT_CODE,
	output reg CHECK_DONE
);
	localparam ST_IDLE = 1'b0;
	localparam ST_EVAL = 1'b1;

	function mapped;
		input [6:0] a;
		begin
			mapped = (a[1:0] == 2'h0) && (a <= `LDC_A_STK_HI);
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	integer k;
	reg [31:0] dw [0:3];
	reg [31:0] ctrl;
	reg [15:0] sel;
	reg [63:0] tss_base;
	reg state;
	reg aw_hold;
	reg w_hold;
	reg [6:0] aw_a;
	reg [31:0] w_d;
	reg [3:0] w_s;
	reg res_done;
	reg res_fault;
	reg [15:0] res_code;
	reg [3:0] res_type;
	reg res_ist_use;
	reg [2:0] res_ist;
	reg [63:0] res_off;
	reg [31:0] res_lim;
	reg [15:0] res_tsel;
	reg [31:0] res_ivt;
	reg [63:0] res_stk;
	reg [31:0] rd_mux;

	wire wr_go;
	wire start;
	wire long_m;
	wire m64;
	wire [1:0] op;
	wire [7:0] vec;
	wire [3:0] ty;
	wire s_bit;
	wire [4:0] up_ty;
	wire [4:0] low_ty;
	wire [63:0] base64;
	wire [63:0] base32;
	wire [63:0] gate_off;
	wire [19:0] lim_raw;
	wire [31:0] lim;
	wire base_ok;
	wire off_ok;
	wire sys_ty_ok;
	wire gate_ty_ok;
	wire gate_is_int;
	wire [31:0] sel_m;

	assign S_AXI_AWREADY = ~aw_hold & ~S_AXI_BVALID;
	assign S_AXI_WREADY = ~w_hold & ~S_AXI_BVALID;
	assign S_AXI_ARREADY = ~S_AXI_RVALID;
	assign wr_go = aw_hold & w_hold;
	assign start = wr_go && ({aw_a[6:2], 2'h0} == `LDC_A_START);

	assign long_m = ctrl[`LDC_C_LONG];
	assign m64 = ctrl[`LDC_C_M64];
	assign op = ctrl[`LDC_C_OP_HI:`LDC_C_OP_LO];
	assign vec = ctrl[`LDC_C_VEC_HI:`LDC_C_VEC_LO];
	assign ty = dw[1][`LDC_D_TYPE_HI:`LDC_D_TYPE_LO];
	assign s_bit = dw[1][`LDC_D_SBIT];
	assign up_ty = dw[3][`LDC_D_SBIT:`LDC_D_TYPE_LO];
	assign low_ty = dw[1][`LDC_D_SBIT:`LDC_D_TYPE_LO];

	// base of the legacy form, then widened by the third dword
	assign base32 = {32'h00000000, dw[1][31:24], dw[1][7:0], dw[0][31:16]};
	assign base64 = {dw[2], base32[31:0]};
	assign gate_off = {dw[2], dw[1][31:16], dw[0][15:0]};
	assign lim_raw = {dw[1][19:16], dw[0][15:0]};
	assign lim = dw[1][`LDC_D_GRAN] ? {lim_raw, `LDC_GRAN_FILL} :
		{12'h000, lim_raw};
	// the selector register keeps only the low half of a merged word
	assign sel_m = merge({16'h0000, sel}, w_d, w_s);

	assign sys_ty_ok = ~s_bit && (ty == `LDC_T_LDT ||
		ty == `LDC_T_TSSA || ty == `LDC_T_TSSB);
	assign gate_is_int = ty == `LDC_T_INTG || ty == `LDC_T_TRAP;
	// 04h..07h and every other code fall out here as well
	assign gate_ty_ok = ~s_bit && (gate_is_int ||
		(op == `LDC_OP_GATE && ty == `LDC_T_CALL));

	ldc_canon #(
		.VA_BITS(VA_BITS)
	) u_base_canon (
		.addr(base64),
		.ok(base_ok)
	);

	ldc_canon #(
		.VA_BITS(VA_BITS)
	) u_off_canon (
		.addr(gate_off),
		.ok(off_ok)
	);

	// checks run as a priority chain so only the first violation reports
	reg next_fault;
	reg [15:0] next_code;
	reg [63:0] next_off;
	reg [2:0] next_ist;
	reg next_ist_use;
	reg [63:0] next_stk;
	reg is_tss;
	always @* begin
		next_fault = 1'b0;
		next_code = 16'h0000;
		next_off = 64'h0000000000000000;
		next_ist = 3'h0;
		next_ist_use = 1'b0;
		next_stk = 64'h0000000000000000;
		is_tss = ty == `LDC_T_TSSA || ty == `LDC_T_TSSB ||
			ty == `LDC_T_T16A || ty == `LDC_T_T16B;
		case (op)
			`LDC_OP_SYS: begin
				next_off = (long_m && m64) ? base64 : base32;
				if (long_m && !sys_ty_ok) begin
					next_fault = 1'b1;
					next_code = sel;
				end else if (long_m && m64 && up_ty != 5'h00) begin
					next_fault = 1'b1;
					next_code = sel;
				end else if (long_m && m64 && !base_ok) begin
					next_fault = 1'b1;
					next_code = sel;
				end else if (is_tss && lim < TSS_MIN_LIM) begin
					next_fault = 1'b1;
					next_code = sel;
				end
			end
			`LDC_OP_GATE, `LDC_OP_INT: begin
				next_off = gate_off;
				if (gate_is_int)
					next_ist = dw[1][`LDC_D_IST_HI:0];
				// the count field of a call gate is never looked at
				if (!long_m) begin
					next_fault = 1'b0;
				end else if (!gate_ty_ok) begin
					next_fault = 1'b1;
					next_code = (op == `LDC_OP_INT) ? {8'h00, vec} : sel;
				end else if (ty == `LDC_T_CALL && up_ty != 5'h00) begin
					next_fault = 1'b1;
					next_code = sel;
				end else if (!ctrl[`LDC_C_CSL] || ctrl[`LDC_C_CSD]) begin
					next_fault = 1'b1;
					next_code = (ty == `LDC_T_CALL) ? dw[0][31:16] :
						{8'h00, vec};
				end else if (!off_ok) begin
					next_fault = 1'b1;
					next_code = 16'h0000;
				end
				if (long_m && gate_is_int && next_ist != 3'h0) begin
					next_ist_use = 1'b1;
					next_stk = tss_base + STK_TBL_OFF +
						({61'h0, next_ist - 3'h1} << `LDC_STK_SH);
				end
			end
			`LDC_OP_LEG: begin
				// an upper half read as legacy shows an illegal zero type
				if (low_ty == 5'h00) begin
					next_fault = 1'b1;
					next_code = sel;
				end
			end
			default: begin
				next_fault = 1'b0;
			end
		endcase
	end

	// check sequencer and result registers
	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			state <= ST_IDLE;
			FAULT <= 1'b0;
			FAULT_CODE <= 16'h0000;
			CHECK_DONE <= 1'b0;
			res_done <= 1'b0;
			res_fault <= 1'b0;
			res_code <= 16'h0000;
			res_type <= 4'h0;
			res_ist_use <= 1'b0;
			res_ist <= 3'h0;
			res_off <= 64'h0000000000000000;
			res_lim <= 32'h00000000;
			res_tsel <= 16'h0000;
			res_ivt <= 32'h00000000;
			res_stk <= 64'h0000000000000000;
		end else begin
			FAULT <= 1'b0;
			CHECK_DONE <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (start) begin
						state <= ST_EVAL;
						res_done <= 1'b0;
					end
				end
				ST_EVAL: begin
					state <= ST_IDLE;
					FAULT <= next_fault;
					FAULT_CODE <= next_code;
					CHECK_DONE <= 1'b1;
					res_done <= 1'b1;
					res_fault <= next_fault;
					res_code <= next_code;
					res_type <= ty;
					res_ist_use <= next_ist_use;
					res_ist <= next_ist;
					res_off <= next_off;
					res_lim <= lim;
					res_tsel <= dw[0][31:16];
					res_ivt <= {24'h000000, vec} << `LDC_IVT_SH;
					res_stk <= next_stk;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// write channel: address and data taken in either order
	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_a <= 7'h00;
			w_d <= 32'h00000000;
			w_s <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `LDC_RESP_OK;
			ctrl <= 32'h00000000;
			sel <= 16'h0000;
			tss_base <= 64'h0000000000000000;
			for (k = 0; k < 4; k = k + 1)
				dw[k] <= 32'h00000000;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_hold <= 1'b1;
				aw_a <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_hold <= 1'b1;
				w_d <= S_AXI_WDATA;
				w_s <= S_AXI_WSTRB;
			end
			if (S_AXI_BVALID && S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
			if (wr_go) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= mapped(aw_a) ? `LDC_RESP_OK : `LDC_RESP_ERR;
				case ({aw_a[6:2], 2'h0})
					`LDC_A_DW0, `LDC_A_DW1, `LDC_A_DW2, `LDC_A_DW3:
						dw[aw_a[3:2]] <= merge(dw[aw_a[3:2]], w_d, w_s);
					`LDC_A_CTRL: ctrl <= merge(ctrl, w_d, w_s);
					`LDC_A_SEL: sel <= sel_m[15:0];
					`LDC_A_TSSB_LO:
						tss_base[31:0] <= merge(tss_base[31:0], w_d, w_s);
					`LDC_A_TSSB_HI:
						tss_base[63:32] <= merge(tss_base[63:32], w_d, w_s);
					default: begin
						aw_a <= aw_a;
					end
				endcase
			end
		end
	end

	// read data selection
	always @* begin
		rd_mux = 32'h00000000;
		case ({S_AXI_ARADDR[6:2], 2'h0})
			`LDC_A_DW0: rd_mux = dw[0];
			`LDC_A_DW1: rd_mux = dw[1];
			`LDC_A_DW2: rd_mux = dw[2];
			`LDC_A_DW3: rd_mux = dw[3];
			`LDC_A_CTRL: rd_mux = ctrl;
			`LDC_A_SEL: rd_mux = {16'h0000, sel};
			`LDC_A_STAT: begin
				rd_mux[`LDC_S_DONE] = res_done;
				rd_mux[`LDC_S_FAULT] = res_fault;
				rd_mux[`LDC_S_TYPE_HI:`LDC_S_TYPE_LO] = res_type;
				rd_mux[`LDC_S_ISTUSE] = res_ist_use;
				rd_mux[`LDC_S_IST_HI:`LDC_S_IST_LO] = res_ist;
				rd_mux[`LDC_S_CODE_HI:`LDC_S_CODE_LO] = res_code;
			end
			`LDC_A_OFF_LO: rd_mux = res_off[31:0];
			`LDC_A_OFF_HI: rd_mux = res_off[63:32];
			`LDC_A_LIMIT: rd_mux = res_lim;
			`LDC_A_TSEL: rd_mux = {16'h0000, res_tsel};
			`LDC_A_TSSB_LO: rd_mux = tss_base[31:0];
			`LDC_A_TSSB_HI: rd_mux = tss_base[63:32];
			`LDC_A_IVTA: rd_mux = res_ivt;
			`LDC_A_STK_LO: rd_mux = res_stk[31:0];
			`LDC_A_STK_HI: rd_mux = res_stk[63:32];
			default: rd_mux = 32'h00000000;
		endcase
	end

	// read channel: one beat, answered the edge after the address
	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `LDC_RESP_OK;
		end else begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= mapped(S_AXI_ARADDR) ? rd_mux : 32'h00000000;
				S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? `LDC_RESP_OK :
					`LDC_RESP_ERR;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end
endmodule // ldc_checker

// *** bench/ldc_checker_assertions.sv ***
// concurrent checks on the ports of the descriptor checker
module ldc_chk_sva (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic FAULT,
	input wire logic [15:0] FAULT_CODE,
	input wire logic CHECK_DONE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	property p_fault_done;
		FAULT |-> CHECK_DONE;
	endproperty
	a_fault_done: assert property (p_fault_done)
		else $error("fault without done");
	property p_done_pulse;
		CHECK_DONE |=> !CHECK_DONE && !FAULT;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done or fault longer than one cycle");
	property p_code_hold;
		!CHECK_DONE |-> $stable(FAULT_CODE);
	endproperty
	a_code_hold: assert property (p_code_hold)
		else $error("error code moved outside a result");
	property p_done_cause;
		CHECK_DONE |-> $past(S_AXI_BVALID);
	endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("result without a start write");
	property p_ar_ready;
		S_AXI_ARREADY == !S_AXI_RVALID;
	endproperty
	a_ar_ready: assert property (p_ar_ready)
		else $error("read address ready wrong");
	property p_r_answer;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
	endproperty
	a_r_answer: assert property (p_r_answer)
		else $error("read answer late");
	property p_b_block;
		S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
	endproperty
	a_b_block: assert property (p_b_block)
		else $error("write taken during response");
	property p_b_end;
		S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
	endproperty
	a_b_end: assert property (p_b_end)
		else $error("write response not released");
	c_fault: cover property (FAULT);
	c_pass: cover property (CHECK_DONE && !FAULT);
	c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule // ldc_chk_sva

bind ldc_checker ldc_chk_sva chk (.CLK_SYS, .RST_B, .S_AXI_AWREADY,
	.S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
	.S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .FAULT, .FAULT_CODE,
	.CHECK_DONE);

// *** bench/ldc_desc_mem.sv ***
// descriptor table in system memory, as software fills it
module ldc_desc_mem (
	input wire logic clk,
	input wire logic wr,
	input wire logic raw,
	input wire logic [3:0] idx,
	input wire logic [127:0] wdesc,
	output logic [127:0] rdesc
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [127:0] tbl [0:15];
	logic [127:0] w;
	// raw lets a scenario store a descriptor that software must never write
	always_comb begin
		w = wdesc;
		w[108:104] = 5'h00;
		if (w[43:40] == 4'hc)
			w[36:32] = 5'h00;
	end
	always @(posedge clk) begin
		if (wr)
			tbl[idx] <= raw ? wdesc : w;
	end
	assign rdesc = tbl[idx];
endmodule // ldc_desc_mem

// *** bench/ldc_checker_tb.sv ***
// self-checking bench of the descriptor checker
`include "ldc_map.vh"
module ldc_checker_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [6:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	logic [127:0] md = 0, rq;
	logic mw = 0, mraw = 0;
	logic [1:0] bresp_seen = 0;
	wire awr, wrr, bv, arr, rv, flt, dn;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	wire [15:0] fc;
	int err_count = 0, n_compared = 0;
	always #25 clk = ~clk;
	ldc_desc_mem mem (.clk(clk), .wr(mw), .raw(mraw), .idx(4'h0),
		.wdesc(md), .rdesc(rq));
	ldc_checker dut (.CLK_SYS(clk), .RST_B(rst_b), .S_AXI_AWADDR(awa),
		.S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
		.S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
		.FAULT(flt), .FAULT_CODE(fc), .CHECK_DONE(dn));
	task automatic end_of_test;
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, e, input string m);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic tmo;
		cmp(0, 1, "timeout");
		end_of_test;
	endtask
	// handshakes are judged at the falling edge, acted on at the next rise
	task automatic axw(input logic [6:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		for (int n = 0; n < 20; n++) begin
			@(negedge clk);
			ta = awv & awr;
			tw = wv & wrr;
			tb = bv;
			if (bv)
				bresp_seen = br;
			@(posedge clk);
			if (ta)
				awv <= 0;
			if (tw)
				wv <= 0;
			if (tb) begin
				bry <= 0;
				return;
			end
		end
		tmo;
	endtask
	task automatic axr(input logic [6:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, tb;
		@(posedge clk);
		ara <= a;
		arv <= 1;
		rry <= 1;
		for (int n = 0; n < 20; n++) begin
			@(negedge clk);
			ta = arv & arr;
			tb = rv;
			d = rdat;
			r = rr;
			@(posedge clk);
			if (ta)
				arv <= 0;
			if (tb) begin
				rry <= 0;
				return;
			end
		end
		tmo;
	endtask
	task automatic rchk(input logic [6:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		cmp(d, e, "read data");
	endtask
	function automatic logic [127:0] sd(input logic [3:0] t,
		input logic [63:0] b, input logic [19:0] l, input logic g);
		return {32'h0, b[63:32], b[31:24], g, 3'h0, l[19:16], 4'h8, t,
			b[23:16], b[15:0], l[15:0]};
	endfunction
	function automatic logic [127:0] gd(input logic [3:0] t,
		input logic [63:0] o, input logic [2:0] i);
		return {32'h0, o[63:32], o[31:16], 4'h8, t, 5'h0, i, 16'h0028,
			o[15:0]};
	endfunction
	// fetch from the table, load the words, start and judge the result
	task automatic run(input logic [127:0] ds, input logic raw,
		input logic [15:0] ctl, sel, input logic ef, input logic [15:0] ec);
		@(posedge clk);
		md <= ds;
		mraw <= raw;
		mw <= 1;
		@(posedge clk);
		mw <= 0;
		// the table takes the entry in this edge's update phase, so wait
		@(negedge clk);
		for (int i = 0; i < 4; i++)
			axw(`LDC_A_DW0 + 7'(4 * i), rq[32 * i +: 32]);
		axw(`LDC_A_CTRL, {16'h0, ctl});
		axw(`LDC_A_SEL, {16'h0, sel});
		axw(`LDC_A_START, 32'h0);
		for (int n = 0; n < 10; n++) begin
			@(negedge clk);
			if (dn === 1'b1) begin
				cmp(flt, ef, "fault");
				if (ef)
					cmp(fc, ec, "error code");
				return;
			end
		end
		tmo;
	endtask
	task automatic sc_sys;
		logic [3:0] ty [5] = '{4'h2, 4'h9, 4'hb, 4'h1, 4'h3};
		foreach (ty[k])
			run(sd(ty[k], 0, 20'h100, 0), 0, 16'h3, 16'h40, k > 2, 16'h40);
		run(sd(9, 64'h8000_0000_0000, 20'h100, 0), 0, 16'h3, 16'h48, 1, 16'h48);
		run(sd(9, 0, 20'h66, 0), 0, 16'h3, 16'h50, 1, 16'h50);
		run(sd(9, 64'h1_2345_6789, 20'h66, 1), 0, 16'h1, 16'h50, 0, 0);
		rchk(`LDC_A_LIMIT, 32'h00066fff);
		rchk(`LDC_A_OFF_HI, 32'h0);
		run(sd(9, 64'h1_2345_6789, 20'h66, 1), 0, 16'h3, 16'h50, 0, 0);
		rchk(`LDC_A_OFF_HI, 32'h1);
		rchk(`LDC_A_OFF_LO, 32'h23456789);
		run(sd(2, 0, 20'h100, 0) | (128'h1 << 104), 1, 16'h3, 16'h58, 1, 16'h58);
	endtask
	task automatic sc_gate;
		for (int t = 4; t < 8; t++)
			run(gd(4'(t), 0, 0), 0, 16'h17, 16'h60, 1, 16'h60);
		run(gd(4'hc, 64'h7fff_1234_5678, 0), 0, 16'h15, 16'h60, 0, 0);
		rchk(`LDC_A_OFF_HI, 32'h00007fff);
		rchk(`LDC_A_OFF_LO, 32'h12345678);
		rchk(`LDC_A_TSEL, 32'h00000028);
		run(gd(4'hc, 64'hffff_0000_0000_0000, 0), 0, 16'h17, 16'h60, 1, 0);
		run(gd(4'hc, 0, 0), 0, 16'h07, 16'h60, 1, 16'h28);
		run(gd(4'hc, 0, 0) | (128'h1 << 104), 1, 16'h17, 16'h60, 1, 16'h60);
	endtask
	task automatic sc_int;
		axw(`LDC_A_TSSB_LO, 32'h00001000);
		axw(`LDC_A_TSSB_HI, 32'h0);
		cmp({30'h0, bresp_seen}, {30'h0, `LDC_RESP_OK}, "write response");
		rchk(`LDC_A_TSSB_LO, 32'h00001000);
		run(gd(4'he, 0, 3) | (128'h1f << 104), 1, 16'h211b, 0, 0, 0);
		rchk(`LDC_A_IVTA, 32'h00000210);
		rchk(`LDC_A_STK_LO, 32'h00001034);
		rchk(`LDC_A_STAT, 32'h000007e1);
		run(gd(4'hf, 0, 0), 0, 16'h211b, 0, 0, 0);
		rchk(`LDC_A_STK_LO, 32'h0);
		run(gd(4'hc, 0, 0), 0, 16'h211b, 16'h60, 1, 16'h21);
		run(gd(4'he, 0, 0), 0, 16'h213b, 0, 1, 16'h21);
	endtask
	task automatic sc_leg;
		logic [31:0] d;
		logic [1:0] r;
		run(sd(0, 0, 20'h100, 0), 0, 16'hf, 16'h70, 1, 16'h70);
		run(sd(9, 0, 20'h100, 0), 0, 16'hf, 16'h70, 0, 0);
		rchk(`LDC_A_START, 32'h0);
		axr(7'h44, d, r);
		cmp({30'h0, r}, {30'h0, `LDC_RESP_ERR}, "unmapped response");
		cmp(d, 32'h0, "unmapped read data");
		axw(7'h44, 32'h0);
		cmp({30'h0, bresp_seen}, {30'h0, `LDC_RESP_ERR}, "unmapped write");
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1;
		sc_sys;
		sc_gate;
		sc_int;
		sc_leg;
		end_of_test;
	end
endmodule // ldc_checker_tb
